// >>> core/gnm_top.sv
/*
  Gateway network manager: serial register port, command word decoder,
  node admit/drop sequencing and per-node page registers.
  Assumes the serial port pins are asynchronous to ref_clk and toggle well
  below a quarter of its rate, and that the radio logic shares ref_clk.
*/
`timescale 1ns/100ps
`default_nettype none
module gnm_top #(
  parameter int unsigned JOIN_CYCLES = gnm_pkg::JOIN_TIME_S * gnm_pkg::CLK_HZ,
  // arbitrary signature value marking a live page
  parameter logic [7:0]  LINK_SIG    = 8'h5C
) (
  // clock and reset
  input  wire logic                    ref_clk,
  input  wire logic                    rst_n,
  // serial port pins
  input  wire logic                    sclk,
  input  wire logic                    cs_n,
  input  wire logic                    mosi,
  output logic                         miso,
  output logic                         miso_oe,
  // radio side
  output logic                         join_req,
  output logic [3:0]                   join_node,
  input  wire logic                    join_ack,
  input  wire logic [15:0]             gw_sig_level,
  input  wire logic [6*16-1:0]         node_sig_level,
  output var gnm_pkg::gnm_cmd_s        cmd
);

  localparam int CW = $clog2(JOIN_CYCLES + 1);
  localparam int NP = gnm_pkg::NODE_PAGES;

  ////////////////////////////////////////////////////////////////////////////
  // pin synchronisers: stage 0 is read only by stage 1

  logic [2:0] sclk_q;
  logic [2:0] cs_q;
  logic [1:0] mosi_q;

  always_ff @(posedge ref_clk) begin
    if (!rst_n) begin
      sclk_q <= 3'h0;
      cs_q   <= 3'h7;
      mosi_q <= 2'h0;
    end else begin
      sclk_q <= {sclk_q[1:0], sclk};
      cs_q   <= {cs_q[1:0], cs_n};
      mosi_q <= {mosi_q[0], mosi};
    end
  end

  logic sel;
  logic rise;
  logic fall;
  assign sel  = ~cs_q[1];
  assign rise = sclk_q[1] & ~sclk_q[2];
  assign fall = ~sclk_q[1] & sclk_q[2];

  ////////////////////////////////////////////////////////////////////////////
  // serial shifter, mode 0, msb first

  logic [15:0]        in_q, in_d;
  logic [4:0]         cnt_q, cnt_d;
  logic [15:0]        out_q, out_d;
  logic               word_v;
  gnm_pkg::gnm_word_s word;
  logic [15:0]        rd_data;

  assign word = {in_q[14:0], mosi_q[1]};

  always_comb begin
    in_d   = in_q;
    cnt_d  = cnt_q;
    out_d  = out_q;
    word_v = 1'b0;
    if (!sel) begin
      cnt_d = 5'h00;
    end else if (rise) begin
      in_d = word;
      if (cnt_q == gnm_pkg::LAST_BIT) begin
        cnt_d  = 5'h00;
        word_v = 1'b1;
      end else begin
        cnt_d = cnt_q + 5'h01;
      end
    end
    // the trailing low edge after bit 16 must not eat the reply's msb
    if (sel && fall && cnt_q != 5'h00) begin
      out_d = {out_q[14:0], 1'b0};
    end
    // a read word is answered during the next frame
    if (word_v && !word.wr) begin
      out_d = rd_data;
    end
  end

  always_ff @(posedge ref_clk) begin
    if (!rst_n) begin
      in_q  <= 16'h0000;
      cnt_q <= 5'h00;
      out_q <= 16'h0000;
    end else begin
      in_q  <= in_d;
      cnt_q <= cnt_d;
      out_q <= out_d;
    end
  end

  assign miso    = out_q[15];
  assign miso_oe = sel;

  ////////////////////////////////////////////////////////////////////////////
  // registers, command decode and join sequencing

  logic [2:0]         page_q, page_d;
  logic [15:0]        net_q, net_d;
  logic [3:0]         target_q, target_d;
  gnm_pkg::gnm_cmd_s  cmd_q, cmd_d;
  gnm_pkg::gnm_join_e js_q, js_d;
  logic [CW-1:0]      jcnt_q, jcnt_d;
  logic [3:0]         jnode_q, jnode_d;
  logic [NP-1:0]      link_q, link_d;
  logic [15:0]        tag_q [NP];
  logic [15:0]        tag_d [NP];
  logic [2:0]         pidx;
  logic               page_live;
  logic               free_ok;
  logic [2:0]         free_idx;
  logic               wr_v;
  logic               tgt_wr;

  assign pidx      = page_q - 3'h1;
  assign page_live = (page_q != 3'h0) && (page_q <= 3'(NP)) && link_q[pidx];
  assign wr_v      = word_v && word.wr;
  assign tgt_wr    = wr_v && page_q == 3'h0 && word.addr == gnm_pkg::ADDR_TARGET;

  // lowest page that manages no node yet
  always_comb begin
    free_ok  = 1'b0;
    free_idx = 3'h0;
    for (int i = NP - 1; i >= 0; i--) begin
      if (!link_q[i]) begin
        free_ok  = 1'b1;
        free_idx = 3'(i);
      end
    end
  end

  // read side
  always_comb begin
    rd_data = 16'h0000;
    if (word.addr[6:1] == gnm_pkg::ADDR_PAGE[6:1]) begin
      rd_data = {13'h0000, page_q};
    end else if (page_q == 3'h0) begin
      case (word.addr[6:1])
        gnm_pkg::ADDR_NET[6:1]:    rd_data = net_q;
        gnm_pkg::ADDR_GW_LVL[6:1]: rd_data = gw_sig_level;
        gnm_pkg::ADDR_TARGET[6:1]: rd_data = {12'h000, target_q};
        default:                   rd_data = 16'h0000;
      endcase
    end else if (page_live) begin
      case (word.addr[6:1])
        gnm_pkg::ADDR_TAG[6:1]:      rd_data = tag_q[pidx];
        gnm_pkg::ADDR_NODE_LVL[6:1]: rd_data = node_sig_level[pidx*16 +: 16];
        default:                     rd_data = 16'h0000;
      endcase
    end
  end

  always_comb begin
    page_d     = page_q;
    net_d      = net_q;
    target_d   = target_q;
    cmd_d      = '0;
    cmd_d.node = target_q;
    js_d       = js_q;
    jcnt_d     = jcnt_q;
    jnode_d    = jnode_q;
    link_d     = link_q;
    tag_d      = tag_q;
    if (wr_v) begin
      if (word.addr == gnm_pkg::ADDR_PAGE) begin
        page_d = word.data[2:0];
      end else if (page_q == 3'h0) begin
        case (word.addr)
          gnm_pkg::ADDR_NET:           net_d[7:0]  = word.data;
          gnm_pkg::ADDR_NET + 7'h01:   net_d[15:8] = word.data;
          gnm_pkg::ADDR_TARGET:        target_d    = word.data[3:0];
          // one pulse per written byte with a used bit set; only set bits act
          gnm_pkg::ADDR_CMD:           cmd_d.act[7:0]  = word.data;
          gnm_pkg::ADDR_CMD + 7'h01:   cmd_d.act[15:8] = word.data;
          default:                     cmd_d.act = 16'h0000;
        endcase
      end
    end
    cmd_d.act   = cmd_d.act & gnm_pkg::CMD_USED;
    // local and per-node actions leave as pulses to their engines
    cmd_d.valid = |cmd_d.act;

    // drop: host has already written the target node
    if (cmd_d.act[gnm_pkg::CMD_DROP] || cmd_d.act[gnm_pkg::CMD_REMOVE]) begin
      for (int i = 0; i < NP; i++) begin
        if (link_q[i] && tag_q[i][3:0] == target_q) begin
          link_d[i] = 1'b0;
          tag_d[i]  = 16'h0000;
        end
      end
    end

    case (js_q)
      gnm_pkg::J_IDLE: begin
        if (cmd_d.act[gnm_pkg::CMD_ADD]) begin
          js_d = gnm_pkg::J_ARMED;
        end
      end
      gnm_pkg::J_ARMED: begin
        if (tgt_wr) begin
          jnode_d = word.data[3:0];
          jcnt_d  = '0;
          js_d    = (word.data[3:0] <= gnm_pkg::MAX_NODE) ? gnm_pkg::J_JOIN
                                                          : gnm_pkg::J_IDLE;
        end
      end
      gnm_pkg::J_JOIN: begin
        jcnt_d = jcnt_q + CW'(1);
        if (join_ack && free_ok) begin
          link_d[free_idx] = 1'b1;
          tag_d[free_idx]  = {LINK_SIG, 4'h0, jnode_q};
          js_d             = gnm_pkg::J_IDLE;
        end else if (jcnt_q == CW'(JOIN_CYCLES - 1)) begin
          js_d = gnm_pkg::J_IDLE;
        end
      end
      default: js_d = gnm_pkg::J_IDLE;
    endcase
  end

  always_ff @(posedge ref_clk) begin
    if (!rst_n) begin
      page_q   <= gnm_pkg::PAGE_RESET;
      net_q    <= gnm_pkg::NET_RESET;
      target_q <= gnm_pkg::TARGET_RESET;
      cmd_q    <= '0;
      js_q     <= gnm_pkg::J_IDLE;
      jcnt_q   <= '0;
      jnode_q  <= 4'h0;
      link_q   <= '0;
      for (int i = 0; i < NP; i++) begin
        tag_q[i] <= 16'h0000;
      end
    end else begin
      page_q   <= page_d;
      net_q    <= net_d;
      target_q <= target_d;
      cmd_q    <= cmd_d;
      js_q     <= js_d;
      jcnt_q   <= jcnt_d;
      jnode_q  <= jnode_d;
      link_q   <= link_d;
      tag_q    <= tag_d;
    end
  end

  assign cmd       = cmd_q;
  assign join_req  = (js_q == gnm_pkg::J_JOIN);
  assign join_node = jnode_q;

  ////////////////////////////////////////////////////////////////////////////
  // checks

  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (!rst_n);

  a_unused_bits: assert property (!(cmd_q.act[14] || cmd_q.act[9] || cmd_q.act[2]))
    else $error("unused command bit launched an action");

  a_cmd_once: assert property (wr_v && page_q == 3'h0 && word.addr == gnm_pkg::ADDR_CMD
      && word.data[gnm_pkg::CMD_FL_SAVE] |=> cmd_q.valid && cmd_q.act[gnm_pkg::CMD_FL_SAVE]
      ##1 !cmd_q.valid)
    else $error("command pulse not exactly one cycle");

  a_admit_start: assert property (js_q == gnm_pkg::J_ARMED && tgt_wr
      && word.data[3:0] <= gnm_pkg::MAX_NODE |=> join_req && join_node == $past(word.data[3:0]))
    else $error("admit did not start after node write");

  a_join_bound: assert property (join_req |-> jcnt_q < CW'(JOIN_CYCLES))
    else $error("join outlived its time limit");

  a_join_tag: assert property (join_req && join_ack && free_ok |=> !join_req
      && tag_q[$past(free_idx)] == {LINK_SIG, 4'h0, $past(jnode_q)})
    else $error("admitted page tag wrong");

  // the page select register stays readable on every page, so it is left out
  a_idle_zero: assert property (word_v && !word.wr && page_q != 3'h0 && !page_live
      && word.addr[6:1] != gnm_pkg::ADDR_PAGE[6:1] |=> out_q == 16'h0000)
    else $error("unconnected page read nonzero");

  a_net_reset: assert property ($rose(rst_n) |-> net_q == gnm_pkg::NET_RESET
      && target_q == gnm_pkg::TARGET_RESET)
    else $error("reset value wrong");

  a_drop_clears: assert property (cmd_q.valid && cmd_q.act[gnm_pkg::CMD_DROP]
      |-> !(link_q[0] && tag_q[0][3:0] == $past(target_q)))
    else $error("dropped node still linked");

endmodule : gnm_top
`default_nettype wire

// >>> core/gnm_pkg.sv
/*
  Shared constants and carriers for the gateway network manager: register
  offsets, reset values, command bit positions, join timing and the packed
  structs that cross module boundaries.
  Assumes a single 25 MHz system clock.
*/
package gnm_pkg;

  localparam int unsigned CLK_HZ      = 25_000_000;
  localparam int unsigned JOIN_TIME_S = 10;
  localparam int unsigned NODE_PAGES  = 6;
  localparam logic [3:0]  MAX_NODE    = 4'h6;

  // byte addresses of the low byte of each register
  localparam logic [6:0]  ADDR_PAGE     = 7'h00;
  localparam logic [6:0]  ADDR_NET      = 7'h02;
  localparam logic [6:0]  ADDR_GW_LVL   = 7'h0A;
  localparam logic [6:0]  ADDR_CMD      = 7'h12;
  localparam logic [6:0]  ADDR_TARGET   = 7'h14;
  localparam logic [6:0]  ADDR_TAG      = 7'h02;
  localparam logic [6:0]  ADDR_NODE_LVL = 7'h5A;

  localparam logic [15:0] NET_RESET    = 16'h1234;
  localparam logic [3:0]  TARGET_RESET = 4'h0;
  localparam logic [2:0]  PAGE_RESET   = 3'h0;

  // bits 14, 9 and 2 launch nothing
  localparam logic [15:0] CMD_USED = 16'hBDFB;

  localparam int CMD_ADD      = 0;
  localparam int CMD_UPDATE   = 1;
  localparam int CMD_FACTORY  = 3;
  localparam int CMD_DIAG_CLR = 4;
  localparam int CMD_FL_TEST  = 5;
  localparam int CMD_FL_SAVE  = 6;
  localparam int CMD_SW_RESET = 7;
  localparam int CMD_DROP     = 8;
  localparam int CMD_ALM_XFER = 10;
  localparam int CMD_ALM_READ = 11;
  localparam int CMD_ALM_UPD  = 12;
  localparam int CMD_CFG_REQ  = 13;
  localparam int CMD_REMOVE   = 15;

  localparam logic [4:0]  LAST_BIT = 5'h0F;

  typedef enum logic [1:0] {
    J_IDLE  = 2'b00,
    J_ARMED = 2'b01,
    J_JOIN  = 2'b11
  } gnm_join_e;

  typedef struct packed {
    logic       wr;
    logic [6:0] addr;
    logic [7:0] data;
  } gnm_word_s;

  typedef struct packed {
    logic        valid;
    logic [3:0]  node;
    logic [15:0] act;
  } gnm_cmd_s;

endpackage : gnm_pkg

// >>> tb/gnm_host_model.sv
/*
  Host serial master model: 16-bit mode 0 frames, msb first.
  Assumes ref_clk is the block clock; pins move at its falling edge.
*/
`timescale 1ns/100ps
`default_nettype none
module gnm_host_model (
  // clock
  input  wire logic ref_clk,
  // serial pins
  input  wire logic miso,
  output logic      sclk,
  output logic      cs_n,
  output logic      mosi
);
  // half sclk period in ref_clk cycles; the block needs at least 4
  int half = 6;

  ////////////////////////////////////////////////////////////////////
  task automatic xfer(input logic [15:0] w, output logic [15:0] r);
    @(negedge ref_clk);
    cs_n = 1'b0;
    for (int i = 15; i >= 0; i--) begin
      mosi = w[i];
      repeat (half) @(negedge ref_clk);
      sclk = 1'b1;
      r[i] = miso;
      repeat (half) @(negedge ref_clk);
      sclk = 1'b0;
    end
    repeat (8) @(negedge ref_clk);
    cs_n = 1'b1;
    // released line flips so a stale bit never passes for data
    mosi = ~mosi;
    repeat (half) @(negedge ref_clk);
  endtask : xfer

  initial begin
    sclk = 1'b0;
    cs_n = 1'b1;
    mosi = 1'b0;
  end
endmodule : gnm_host_model
`default_nettype wire

// >>> tb/test_gnm_top.sv
/*
  Self-checking bench for gnm_top: registers, command bits, admit,
  give-up and drop. Assumes gnm_host_model as the serial host.
*/
`timescale 1ns/100ps
`default_nettype none
module test_gnm_top;
  localparam int         JC  = 200;
  localparam logic [7:0] SIG = 8'h5C;
  logic              ref_clk, rst_n, sclk, cs_n, mosi, miso, miso_oe;
  logic              join_req, join_ack;
  logic [3:0]        join_node;
  logic [15:0]       gw_lvl, d;
  logic [95:0]       node_lvl;
  gnm_pkg::gnm_cmd_s cmd, last;
  int                num_errors, n_tests, pulses, oe_n, i;

  gnm_top #(.JOIN_CYCLES(JC), .LINK_SIG(SIG)) uut (
    .ref_clk(ref_clk), .rst_n(rst_n), .sclk(sclk), .cs_n(cs_n),
    .mosi(mosi), .miso(miso), .miso_oe(miso_oe), .join_req(join_req),
    .join_node(join_node), .join_ack(join_ack), .gw_sig_level(gw_lvl),
    .node_sig_level(node_lvl), .cmd(cmd));
  gnm_host_model host (.ref_clk(ref_clk), .miso(miso), .sclk(sclk),
    .cs_n(cs_n), .mosi(mosi));

  ////////////////////////////////////////////////////////////////////
  // outputs are looked at on the falling edge, where they have settled
  always @(negedge ref_clk) begin
    if (cmd.valid === 1'b1) begin
      pulses++;
      last = cmd;
    end
    if (miso_oe === 1'b1) begin
      oe_n++;
    end
  end

  task automatic stop_test;
    if (num_errors == 0 && n_tests > 0) $display("All tests passed");
    else $display("Some tests failed");
    $finish;
  endtask : stop_test

  task automatic chk(input string nm, input logic [15:0] e, g);
    n_tests++;
    if (g !== e) begin
      num_errors++;
      $display("Error %s expected %h seen %h", nm, e, g);
    end
  endtask : chk

  task automatic wr(input logic [6:0] a, input logic [7:0] v);
    logic [15:0] r;
    host.xfer({1'b1, a, v}, r);
  endtask : wr

  // a reply arrives in the frame after its request
  task automatic rc(input string nm, input logic [6:0] a, input logic [15:0] e);
    logic [15:0] r;
    host.xfer({1'b0, a, 8'h00}, r);
    host.xfer({1'b0, a, 8'h00}, r);
    chk(nm, e, r);
  endtask : rc

  ////////////////////////////////////////////////////////////////////
  initial begin
    ref_clk = 1'b0;
    forever #20 ref_clk = ~ref_clk;
  end

  initial begin
    repeat (80000) @(posedge ref_clk);
    chk("watchdog", 16'h0000, 16'h0001);
    stop_test();
  end

  initial begin
    rst_n = 1'b0;
    join_ack = 1'b0;
    gw_lvl = 16'hFFA0;
    node_lvl = 96'h0006_0005_0004_0003_FFF1_FFA0;
    repeat (3) @(negedge ref_clk);
    rst_n = 1'b1;
    repeat (4) @(negedge ref_clk);
    chk("idle oe", 16'h0000, {15'h0000, miso_oe});
    rc("net", 7'h02, 16'h1234);
    rc("target", 7'h14, 16'h0000);
    rc("gw level", 7'h0A, 16'hFFA0);
    rc("cmd read", 7'h12, 16'h0000);
    host.half = 9;
    wr(7'h03, 8'hAB);
    wr(7'h02, 8'h56);
    rc("net rw", 7'h02, 16'hAB56);
    host.half = 6;
    wr(7'h14, 8'h04);
    for (int k = 0; k < 16; k++) begin
      pulses = 0;
      oe_n = 0;
      wr(k < 8 ? 7'h12 : 7'h13, 8'h01 << (k % 8));
      chk("pulses", (16'hBDFB >> k) & 16'h0001, 16'(pulses));
      // select is low for 16 periods of 12 cycles plus 8 cycles of tail
      chk("oe cycles", 16'h00C8, 16'(oe_n));
      if (((16'hBDFB >> k) & 16'h0001) != 16'h0000) begin
        chk("act", 16'h0001 << k, last.act);
        chk("node", 16'h0004, {12'h000, last.node});
      end
    end
    wr(7'h00, 8'h02);
    rc("idle tag", 7'h02, 16'h0000);
    rc("idle level", 7'h5A, 16'h0000);
    wr(7'h00, 8'h00);
    wr(7'h12, 8'h01);
    repeat (12500) @(negedge ref_clk);
    wr(7'h14, 8'h03);
    chk("join", 16'h0013, {11'h000, join_req, join_node});
    join_ack = 1'b1;
    @(negedge ref_clk);
    join_ack = 1'b0;
    @(negedge ref_clk);
    chk("join done", 16'h0000, {15'h0000, join_req});
    wr(7'h00, 8'h01);
    rc("tag", 7'h02, {SIG, 8'h03});
    rc("node level", 7'h5A, 16'hFFA0);
    wr(7'h00, 8'h00);
    wr(7'h12, 8'h01);
    wr(7'h14, 8'h05);
    chk("join 5", 16'h0015, {11'h000, join_req, join_node});
    // the join already ran during the tail of the write, so JC is an upper bound
    for (i = 0; i < JC && join_req !== 1'b0; i++) @(negedge ref_clk);
    chk("give up", 16'h0000, {15'h0000, join_req});
    wr(7'h12, 8'h01);
    wr(7'h14, 8'h07);
    chk("bad node", 16'h0000, {15'h0000, join_req});
    wr(7'h00, 8'h02);
    rc("no link", 7'h02, 16'h0000);
    wr(7'h00, 8'h00);
    wr(7'h14, 8'h03);
    wr(7'h13, 8'h01);
    wr(7'h00, 8'h01);
    rc("dropped", 7'h02, 16'h0000);
    stop_test();
  end
endmodule : test_gnm_top
`default_nettype wire
